/* File: design/comparator_pair.sv */
// Control and status logic for two voltage comparators behind the SFR port.
//
// Contract
// [RULE1] Two channels with identical control behaviour.
// [RULE2] Raw unclocked output plus clock-latched output.
// [RULE3] Disabled channel drives output low, core off.
// [RULE4] Control bit 7 enables channel, resets 0.
// [RULE5] Control bit 6 reads current comparator result.
// [RULE6] Falling transition sets flag in bit 4.
// [RULE7] Rising transition sets flag in bit 5.
// [RULE8] Edge flags stay set until software clears.
// [RULE9] Mode bit 5 gates rising-edge request.
// [RULE10] Mode bit 4 gates falling-edge request.
// [RULE11] Control bits 3:2 select positive hysteresis.
// [RULE12] Control bits 1:0 select negative hysteresis.
// [RULE13] Mode bits 1:0 select response, reset 2.
// [RULE14] Unused mode bits read zero, ignore writes.
// [RULE15] Software clears flags after enable or changes.
// [RULE16] Channel 0 result offered to reset logic.
// [RULE17] Edges found on synchronised current versus previous.
`timescale 1ns/10ps
module comparator_pair (
    input  wire logic                                     ref_clk,
    input  wire logic                                     resetn,
    input  wire cmp_pkg::sfr_req_t                        sfr_req,
    output logic      [7:0]                               sfr_rdata,
    input  wire logic [cmp_pkg::NUM_CH-1:0]               core_result,
    output cmp_pkg::core_cfg_t [cmp_pkg::NUM_CH-1:0]      core_cfg,
    output logic      [cmp_pkg::NUM_CH-1:0]               raw_output,
    output logic      [cmp_pkg::NUM_CH-1:0]               latched_output,
    output logic      [cmp_pkg::NUM_CH-1:0]               rise_irq,
    output logic      [cmp_pkg::NUM_CH-1:0]               fall_irq,
    output logic                                          reset_src_result
);

    // Synchronised reset used by every flip-flop below.
    logic                                rst_n;
    // Comparator results after crossing into ref_clk.
    logic [cmp_pkg::NUM_CH-1:0]          sync_result;
    // Synchronised result masked by the channel enable.
    logic [cmp_pkg::NUM_CH-1:0]          cur_result;
    // One-cycle edge events from the sample comparison.
    logic [cmp_pkg::NUM_CH-1:0]          rise_event;
    logic [cmp_pkg::NUM_CH-1:0]          fall_event;
    // Write strobes decoded per channel and register.
    logic [cmp_pkg::NUM_CH-1:0]          ctl_wr;
    logic [cmp_pkg::NUM_CH-1:0]          mode_wr;

    // Control registers and their next values.
    cmp_pkg::ctl_t  [cmp_pkg::NUM_CH-1:0] ctl_reg;
    cmp_pkg::ctl_t  [cmp_pkg::NUM_CH-1:0] ctl_next;
    // Mode registers and their next values.
    cmp_pkg::mode_t [cmp_pkg::NUM_CH-1:0] mode_reg;
    cmp_pkg::mode_t [cmp_pkg::NUM_CH-1:0] mode_next;
    // Previous masked sample for edge detection.
    logic [cmp_pkg::NUM_CH-1:0]          prev_reg;
    logic [cmp_pkg::NUM_CH-1:0]          prev_next;
    // Registered read data.
    logic [7:0]                          rdata_reg;
    logic [7:0]                          rdata_next;
    // Registered port outputs.
    logic [cmp_pkg::NUM_CH-1:0]          latched_reg;
    logic [cmp_pkg::NUM_CH-1:0]          latched_next;
    logic [cmp_pkg::NUM_CH-1:0]          rise_irq_reg;
    logic [cmp_pkg::NUM_CH-1:0]          rise_irq_next;
    logic [cmp_pkg::NUM_CH-1:0]          fall_irq_reg;
    logic [cmp_pkg::NUM_CH-1:0]          fall_irq_next;
    logic                                rst_src_reg;
    logic                                rst_src_next;

    // The channel decode below only knows two channels.
    if (cmp_pkg::NUM_CH != 2) begin : g_check
        $error("comparator_pair serves exactly two channels");
    end

    // Address of a channel's control register.
    function automatic logic [7:0] ctl_addr(input int ch);
        return (ch == 0) ? cmp_pkg::CH0_CTL_OFFSET : cmp_pkg::CH1_CTL_OFFSET;
    endfunction

    // Address of a channel's mode register.
    function automatic logic [7:0] mode_addr(input int ch);
        return (ch == 0) ? cmp_pkg::CH0_MODE_OFFSET : cmp_pkg::CH1_MODE_OFFSET;
    endfunction

    // Read image of a control register with the live result in bit 6.
    function automatic logic [7:0] ctl_image(input cmp_pkg::ctl_t c, input logic res);
        return {c.enable, res, c.rise_flag, c.fall_flag, c.pos_hys, c.neg_hys};
    endfunction

    // Read image of a mode register; the unused bits are forced to zero.
    function automatic logic [7:0] mode_image(input cmp_pkg::mode_t m);
        return {2'b00, m.rise_irq_enable, m.fall_irq_enable, 2'b00, m.response_mode};
    endfunction

    // Release of the external reset through two flip-flops.
    reset_sync u_reset_sync (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .rst_sync_n (rst_n)
    );

    // Bring the asynchronous comparator results into the clock domain.
    level_sync #(
        .WIDTH  (cmp_pkg::NUM_CH),
        .STAGES (cmp_pkg::SYNC_STAGES)
    ) u_result_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .din     (core_result),
        .dout    (sync_result)
    );

    // Masking, edge detection and write decode for each channel.
    always_comb begin
        for (int ch = 0; ch < cmp_pkg::NUM_CH; ch++) begin
            // [RULE3] disabled reads low
            cur_result[ch] = sync_result[ch] & ctl_reg[ch].enable;
            // [RULE17] synchronised sample compare
            rise_event[ch] = cur_result[ch] & ~prev_reg[ch];
            fall_event[ch] = ~cur_result[ch] & prev_reg[ch];
            // [RULE1] identical per-channel decode
            ctl_wr[ch]     = sfr_req.wr && (sfr_req.addr == ctl_addr(ch));
            mode_wr[ch]    = sfr_req.wr && (sfr_req.addr == mode_addr(ch));
        end
    end

    // Next values of the control and mode registers.
    always_comb begin
        ctl_next  = ctl_reg;
        mode_next = mode_reg;
        prev_next = cur_result;
        for (int ch = 0; ch < cmp_pkg::NUM_CH; ch++) begin
            // A software write replaces every writable control field.
            if (ctl_wr[ch]) begin
                // [RULE4] enable bit write
                ctl_next[ch].enable    = sfr_req.wdata[cmp_pkg::CTL_ENABLE_BIT];
                // [RULE8] software clears flags
                ctl_next[ch].rise_flag = sfr_req.wdata[cmp_pkg::CTL_RISE_BIT];
                ctl_next[ch].fall_flag = sfr_req.wdata[cmp_pkg::CTL_FALL_BIT];
                // [RULE11] positive hysteresis field
                ctl_next[ch].pos_hys   = cmp_pkg::hys_t'(
                    sfr_req.wdata[cmp_pkg::CTL_POS_HYS_LSB +: 2]);
                // [RULE12] negative hysteresis field
                ctl_next[ch].neg_hys   = cmp_pkg::hys_t'(
                    sfr_req.wdata[cmp_pkg::CTL_NEG_HYS_LSB +: 2]);
            end
            // An edge in the same cycle as a clearing write still sets the flag.
            // [RULE7] rising edge sets flag
            if (rise_event[ch]) begin
                ctl_next[ch].rise_flag = 1'b1;
            end
            // [RULE6] falling edge sets flag
            if (fall_event[ch]) begin
                ctl_next[ch].fall_flag = 1'b1;
            end
            // Mode write; bits 7:6 and 3:2 have no storage.
            if (mode_wr[ch]) begin
                // [RULE14] unused bits dropped
                mode_next[ch].rise_irq_enable = sfr_req.wdata[cmp_pkg::MODE_RISE_IE_BIT];
                mode_next[ch].fall_irq_enable = sfr_req.wdata[cmp_pkg::MODE_FALL_IE_BIT];
                // [RULE13] response mode field
                mode_next[ch].response_mode   = cmp_pkg::resp_t'(
                    sfr_req.wdata[cmp_pkg::MODE_RESP_LSB +: 2]);
            end
        end
    end

    // Registers of control state.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int ch = 0; ch < cmp_pkg::NUM_CH; ch++) begin
                ctl_reg[ch]  <= cmp_pkg::ctl_t'(cmp_pkg::CTL_RESET_VALUE[6:0]);
                mode_reg[ch] <= cmp_pkg::mode_t'({cmp_pkg::MODE_RESET_VALUE[5:4],
                                                  cmp_pkg::MODE_RESET_VALUE[1:0]});
            end
            prev_reg <= '0;
        end else begin
            ctl_reg  <= ctl_next;
            mode_reg <= mode_next;
            prev_reg <= prev_next;
        end
    end

    // Read data: a read latches the image of the addressed register.
    always_comb begin
        rdata_next = rdata_reg;
        if (sfr_req.rd) begin
            // Unmapped addresses read as zero.
            rdata_next = 8'h00;
            for (int ch = 0; ch < cmp_pkg::NUM_CH; ch++) begin
                if (sfr_req.addr == ctl_addr(ch)) begin
                    // [RULE5] live result readback
                    rdata_next = ctl_image(ctl_reg[ch], cur_result[ch]);
                end
                if (sfr_req.addr == mode_addr(ch)) begin
                    // [RULE14] unused read zero
                    rdata_next = mode_image(mode_reg[ch]);
                end
            end
        end
    end

    // Next values of the port outputs.
    always_comb begin
        for (int ch = 0; ch < cmp_pkg::NUM_CH; ch++) begin
            // [RULE2] clock-latched output
            latched_next[ch]  = cur_result[ch];
            // [RULE9] rising request gate
            rise_irq_next[ch] = ctl_reg[ch].rise_flag & mode_reg[ch].rise_irq_enable;
            // [RULE10] falling request gate
            fall_irq_next[ch] = ctl_reg[ch].fall_flag & mode_reg[ch].fall_irq_enable;
        end
        // [RULE16] channel 0 reset source
        rst_src_next = cur_result[0];
    end

    // Registers of the port outputs and read data.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg    <= cmp_pkg::RDATA_RESET;
            latched_reg  <= '0;
            rise_irq_reg <= '0;
            fall_irq_reg <= '0;
            rst_src_reg  <= 1'b0;
        end else begin
            rdata_reg    <= rdata_next;
            latched_reg  <= latched_next;
            rise_irq_reg <= rise_irq_next;
            fall_irq_reg <= fall_irq_next;
            rst_src_reg  <= rst_src_next;
        end
    end

    // Settings for the analog cores come straight from the registers.
    always_comb begin
        for (int ch = 0; ch < cmp_pkg::NUM_CH; ch++) begin
            // [RULE3] core powered by enable
            core_cfg[ch].power_on      = ctl_reg[ch].enable;
            core_cfg[ch].pos_hys       = ctl_reg[ch].pos_hys;
            core_cfg[ch].neg_hys       = ctl_reg[ch].neg_hys;
            core_cfg[ch].response_mode = mode_reg[ch].response_mode;
        end
    end

    // The raw path must work without a clock, so it is a gate, not a flip-flop.
    // [RULE2] unclocked raw output
    assign raw_output       = core_result & {ctl_reg[1].enable, ctl_reg[0].enable};
    assign latched_output   = latched_reg;
    assign rise_irq         = rise_irq_reg;
    assign fall_irq         = fall_irq_reg;
    assign reset_src_result = rst_src_reg;
    assign sfr_rdata        = rdata_reg;

    // A rising event is flagged on the next edge.
    a_rise_sets_flag: assert property ( // [RULE7]
        @(posedge ref_clk) disable iff (!rst_n)
        rise_event[0] |=> ctl_reg[0].rise_flag)
        else $error("rising edge did not set the rise flag");

    // A falling event is flagged on the next edge.
    a_fall_sets_flag: assert property ( // [RULE6]
        @(posedge ref_clk) disable iff (!rst_n)
        fall_event[1] |=> ctl_reg[1].fall_flag)
        else $error("falling edge did not set the fall flag");

    // A set flag survives every cycle without a control write.
    a_flag_sticky: assert property ( // [RULE8]
        @(posedge ref_clk) disable iff (!rst_n)
        ctl_reg[0].rise_flag && !ctl_wr[0] |=> ctl_reg[0].rise_flag)
        else $error("rise flag cleared without a write");

    // One transition yields one event only; a rise may only be followed by a real drop.
    a_edge_once: assert property ( // [RULE17]
        @(posedge ref_clk) disable iff (!rst_n)
        rise_event[0] |=> !rise_event[0] && (fall_event[0] == !cur_result[0]))
        else $error("edge event lasted more than one cycle");

    // A disabled channel keeps both outputs low.
    a_disabled_low: assert property ( // [RULE3]
        @(posedge ref_clk) disable iff (!rst_n)
        !ctl_reg[0].enable |-> !raw_output[0] ##1 !latched_output[0])
        else $error("disabled channel drove its output");

    // Writing bit 7 enables the channel and powers its core.
    a_enable_write: assert property ( // [RULE4]
        @(posedge ref_clk) disable iff (!rst_n)
        ctl_wr[0] && sfr_req.wdata[7] |=> core_cfg[0].power_on)
        else $error("enable write did not power the core");

    // Rising request follows flag and enable one cycle later.
    a_rise_irq_gate: assert property ( // [RULE9]
        @(posedge ref_clk) disable iff (!rst_n)
        ##1 rise_irq[0] == $past(ctl_reg[0].rise_flag && mode_reg[0].rise_irq_enable))
        else $error("rising request does not match flag and enable");

    // Falling request follows flag and enable one cycle later.
    a_fall_irq_gate: assert property ( // [RULE10]
        @(posedge ref_clk) disable iff (!rst_n)
        ##1 fall_irq[1] == $past(ctl_reg[1].fall_flag && mode_reg[1].fall_irq_enable))
        else $error("falling request does not match flag and enable");

    // Hysteresis written is handed to the core on the next edge.
    a_hys_to_core: assert property ( // [RULE11]
        @(posedge ref_clk) disable iff (!rst_n)
        ctl_wr[0] |=> core_cfg[0].pos_hys == $past(sfr_req.wdata[3:2])
                   && core_cfg[0].neg_hys == $past(sfr_req.wdata[1:0]))
        else $error("hysteresis setting not passed to the core");

    // Unused mode bits read back as zero.
    a_mode_unused: assert property ( // [RULE14]
        @(posedge ref_clk) disable iff (!rst_n)
        sfr_req.rd && sfr_req.addr == cmp_pkg::CH0_MODE_OFFSET
        |=> sfr_rdata[7:6] == 2'b00 && sfr_rdata[3:2] == 2'b00)
        else $error("unused mode bits read nonzero");

    // Response mode is 2 until first written.
    a_mode_reset: assert property ( // [RULE13]
        @(posedge ref_clk)
        $rose(rst_n) |-> mode_reg[0].response_mode == cmp_pkg::RESP_MODE2)
        else $error("response mode not 2 after reset");

    // Read of control shows the live result sampled at the read.
    a_result_read: assert property ( // [RULE5]
        @(posedge ref_clk) disable iff (!rst_n)
        sfr_req.rd && sfr_req.addr == cmp_pkg::CH0_CTL_OFFSET
        |=> sfr_rdata[6] == $past(cur_result[0]))
        else $error("result bit does not show the comparator state");

    // Reset logic sees the channel 0 result one edge later.
    a_reset_source: assert property ( // [RULE16]
        @(posedge ref_clk) disable iff (!rst_n)
        ##1 reset_src_result == $past(cur_result[0]))
        else $error("reset source does not follow channel 0");

endmodule

/* File: include/cmp_pkg.sv */
// Shared constants, encodings and carrier types for the comparator control block.
package cmp_pkg;

    // Number of comparator channels served by the block.
    localparam int NUM_CH = 2;

    // Depth of the synchroniser that brings each comparator result into ref_clk.
    localparam int SYNC_STAGES = 2;

    // Register addresses on the special-function-register port.
    localparam logic [7:0] CH0_CTL_OFFSET  = 8'h9B;
    localparam logic [7:0] CH0_MODE_OFFSET = 8'h9D;
    localparam logic [7:0] CH1_CTL_OFFSET  = 8'h9A;
    localparam logic [7:0] CH1_MODE_OFFSET = 8'h9C;

    // Field positions in the control register.
    localparam int CTL_ENABLE_BIT  = 7;
    localparam int CTL_RESULT_BIT  = 6;
    localparam int CTL_RISE_BIT    = 5;
    localparam int CTL_FALL_BIT    = 4;
    localparam int CTL_POS_HYS_LSB = 2;
    localparam int CTL_NEG_HYS_LSB = 0;

    // Field positions in the mode register.
    localparam int MODE_RISE_IE_BIT = 5;
    localparam int MODE_FALL_IE_BIT = 4;
    localparam int MODE_RESP_LSB    = 0;

    // Values after reset.
    localparam logic [7:0] CTL_RESET_VALUE  = 8'h00;
    localparam logic [7:0] MODE_RESET_VALUE = 8'h02;
    localparam logic [7:0] RDATA_RESET      = 8'h00;

    // Hysteresis amount handed to the analog core.
    typedef enum logic [1:0] {
        HYS_OFF  = 2'b00,
        HYS_5MV  = 2'b01,
        HYS_10MV = 2'b10,
        HYS_20MV = 2'b11
    } hys_t;

    // Response mode, from fastest and hungriest to slowest and thriftiest.
    typedef enum logic [1:0] {
        RESP_MODE0 = 2'b00,
        RESP_MODE1 = 2'b01,
        RESP_MODE2 = 2'b10,
        RESP_MODE3 = 2'b11
    } resp_t;

    // Writable content of a control register.
    typedef struct packed {
        logic enable;
        logic rise_flag;
        logic fall_flag;
        hys_t pos_hys;
        hys_t neg_hys;
    } ctl_t;

    // Writable content of a mode register.
    typedef struct packed {
        logic  rise_irq_enable;
        logic  fall_irq_enable;
        resp_t response_mode;
    } mode_t;

    // One request on the special-function-register port.
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } sfr_req_t;

    // Settings driven to one analog comparator core.
    typedef struct packed {
        logic  power_on;
        hys_t  pos_hys;
        hys_t  neg_hys;
        resp_t response_mode;
    } core_cfg_t;

endpackage

/* File: design/reset_sync.sv */
// Reset synchroniser: asynchronous assertion, release through two flip-flops.
`timescale 1ns/10ps
module reset_sync (
    input  wire logic ref_clk,
    input  wire logic resetn,
    output logic      rst_sync_n
);

    // First and second stage of the release chain.
    logic stage1_reg;
    logic stage2_reg;

    // Both stages drop at once on reset and release one edge apart.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= 1'b1;
            stage2_reg <= stage1_reg;
        end
    end

    // Only the second stage leaves the module.
    assign rst_sync_n = stage2_reg;

endmodule

/* File: design/level_sync.sv */
// Multi-stage synchroniser for asynchronous levels.
`timescale 1ns/10ps
module level_sync #(
    parameter int WIDTH  = 2,
    parameter int STAGES = cmp_pkg::SYNC_STAGES
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    // Fewer than two stages would not resolve metastability.
    if (STAGES < 2) begin : g_check
        $error("level_sync needs at least two stages");
    end

    // Chain of stages; stage 0 is read only by stage 1.
    logic [WIDTH-1:0] stage_reg [STAGES];

    // Shift the level along the chain every edge.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < STAGES; i++) begin
                stage_reg[i] <= '0;
            end
        end else begin
            stage_reg[0] <= din;
            for (int i = 1; i < STAGES; i++) begin
                stage_reg[i] <= stage_reg[i-1];
            end
        end
    end

    // The last stage is the settled copy.
    assign dout = stage_reg[STAGES-1];

endmodule

/* File: verif/cmp_core_model.sv */
// Behavioural model of the two analog comparator cores beside the block.
`timescale 1ns/10ps
module cmp_core_model (
    input  wire logic                                      ref_clk,
    input  wire cmp_pkg::core_cfg_t [cmp_pkg::NUM_CH-1:0]  core_cfg,
    input  wire logic               [cmp_pkg::NUM_CH-1:0]  in_level,
    output logic                    [cmp_pkg::NUM_CH-1:0]  core_result
);
    // Pattern shown by a core with no power; it changes every cycle.
    logic [cmp_pkg::NUM_CH-1:0] junk = '0;

    // The pattern toggles so that no stale level can pass for a result.
    always @(posedge ref_clk) begin
        junk <= ~junk;
    end

    always_comb begin
        for (int i = 0; i < cmp_pkg::NUM_CH; i++) begin
            core_result[i] = core_cfg[i].power_on ? in_level[i] : junk[i];
        end
    end
endmodule

/* File: verif/analog_comparator_control_tb_top.sv */
// Self-checking testbench for the comparator control block.
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) begin \
            fails++; \
            $display("BAD %s expected %h seen %h", nm, e, g); \
        end \
    end
module analog_comparator_control_tb_top;
    logic                                     ref_clk;
    logic                                     resetn;
    cmp_pkg::sfr_req_t                        req;
    logic               [7:0]                 sfr_rdata;
    logic               [1:0]                 lvl;
    logic               [1:0]                 core_result;
    cmp_pkg::core_cfg_t [cmp_pkg::NUM_CH-1:0] core_cfg;
    logic               [1:0]                 raw_output;
    logic               [1:0]                 latched_output;
    logic               [1:0]                 rise_irq;
    logic               [1:0]                 fall_irq;
    logic                                     reset_src_result;
    int                                       fails;
    int                                       compares;

    // Device under test.
    comparator_pair u_comparator_pair (
        .ref_clk(ref_clk), .resetn(resetn), .sfr_req(req), .sfr_rdata(sfr_rdata),
        .core_result(core_result), .core_cfg(core_cfg), .raw_output(raw_output),
        .latched_output(latched_output), .rise_irq(rise_irq), .fall_irq(fall_irq),
        .reset_src_result(reset_src_result)
    );

    // Analog cores driven by the bench's input levels.
    cmp_core_model u_cmp_core_model (
        .ref_clk(ref_clk), .core_cfg(core_cfg), .in_level(lvl), .core_result(core_result)
    );

    // Control register image as software should read it.
    function automatic logic [7:0] ctl_img(logic r, logic ri, logic fa, logic [3:0] h);
        return {1'b1, r, ri, fa, h};
    endfunction

    // One register write, driven on falling edges.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge ref_clk);
        req.wr = 1'b0;
    endtask

    // One register read compared against the expected byte.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge ref_clk);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge ref_clk);
        req.rd = 1'b0;
        `CHK("sfr_rdata", e, sfr_rdata)
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic give_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Clock of 10 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Cuts a hang short; the tests need far less than this.
    initial begin
        #100000;
        fails++;
        give_verdict();
    end

    // Main sequence: both channels in turn, random hysteresis and mode.
    initial begin
        logic [7:0] c;
        logic [7:0] m;
        logic [3:0] h;
        logic [1:0] md;
        fails = 0;
        compares = 0;
        resetn = 1'b0;
        req = '0;
        lvl = 2'b00;
        void'($urandom(62424));
        repeat (6) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (3) @(negedge ref_clk);
        rd_chk(8'h9E, 8'h00);
        for (int ch = 0; ch < 2; ch++) begin
            c = ch ? cmp_pkg::CH1_CTL_OFFSET : cmp_pkg::CH0_CTL_OFFSET;
            m = ch ? cmp_pkg::CH1_MODE_OFFSET : cmp_pkg::CH0_MODE_OFFSET;
            h = 4'($urandom % 16);
            md = 2'($urandom % 4);
            rd_chk(c, 8'h00);
            rd_chk(m, 8'h02);
            wr(c, {4'hC, h});
            `CHK("power_on", 1'b1, core_cfg[ch].power_on)
            `CHK("pos_hys", h[3:2], core_cfg[ch].pos_hys)
            `CHK("neg_hys", h[1:0], core_cfg[ch].neg_hys)
            repeat (4) @(negedge ref_clk);
            wr(c, {4'h8, h});
            rd_chk(c, ctl_img(1'b0, 1'b0, 1'b0, h));
            wr(m, {6'h3F, md});
            rd_chk(m, {6'h0C, md});
            `CHK("resp", md, core_cfg[ch].response_mode)
            lvl[ch] = 1'b1;
            #1;
            `CHK("raw", 1'b1, raw_output[ch])
            repeat (6) @(negedge ref_clk);
            `CHK("latched", 1'b1, latched_output[ch])
            `CHK("rise_irq", 1'b1, rise_irq[ch])
            `CHK("fall_irq", 1'b0, fall_irq[ch])
            `CHK("reset_src", (ch == 0), reset_src_result)
            rd_chk(c, ctl_img(1'b1, 1'b1, 1'b0, h));
            lvl[ch] = 1'b0;
            repeat (6) @(negedge ref_clk);
            rd_chk(c, ctl_img(1'b0, 1'b1, 1'b1, h));
            `CHK("fall_irq", 1'b1, fall_irq[ch])
            wr(m, {6'h00, md});
            @(negedge ref_clk);
            `CHK("rise_irq", 1'b0, rise_irq[ch])
            `CHK("fall_irq", 1'b0, fall_irq[ch])
            rd_chk(c, ctl_img(1'b0, 1'b1, 1'b1, h));
            wr(c, {4'h8, h});
            rd_chk(c, ctl_img(1'b0, 1'b0, 1'b0, h));
            wr(c, 8'h00);
            lvl[ch] = 1'b1;
            #1;
            `CHK("raw", 1'b0, raw_output[ch])
            `CHK("power_on", 1'b0, core_cfg[ch].power_on)
            lvl[ch] = 1'b0;
        end
        give_verdict();
    end
endmodule
